// ==== logic/fsh_defs.svh ====
// constants of the fault supervisor: offsets, reset values, limits, timing, alarm codes
`ifndef FSH_DEFS_SVH
`define FSH_DEFS_SVH
// register byte offsets
`define FSH_A_CTRL    8'h00
`define FSH_A_STTHR   8'h04
`define FSH_A_TACHO   8'h08
`define FSH_A_STDLY   8'h0C
`define FSH_A_RTDLY   8'h10
`define FSH_A_STAT    8'h14
`define FSH_A_HEALTH  8'h18
`define FSH_A_FIRST   8'h1C
`define FSH_A_LAST    8'h20
`define FSH_A_HIST    8'h24
`define FSH_A_HEND    8'h48
`define FSH_DEPTH     10
`define FSH_HIDX_W    4
// reset values
`define FSH_CTRL_RST  8'h7F
`define FSH_STTHR_RST 16'h251C
`define FSH_TACHO_RST 16'h01F4
`define FSH_STDLY_RST 16'h012C
`define FSH_RTDLY_RST 16'h0064
// programmable limits (0.01 %, 0.1 %, 0.1 s units)
`define FSH_STTHR_MAX 16'h4E20
`define FSH_TACHO_MAX 16'h03E8
`define FSH_DLY_MIN   16'h0001
`define FSH_DLY_MAX   16'h1770
`define FSH_RX_TOUT   16'h0001
// timing: one delay tick is 100 ms at 100 MHz
`define FSH_TICK_MS   100
`define FSH_CLK_MHZ   100
`define FSH_TICK_CYC  (`FSH_TICK_MS * 1000 * `FSH_CLK_MHZ)
`define FSH_TCNT_W    24
// alarm codes
`define FSH_C_NONE    16'h0000
`define FSH_C_THERM   16'h0010
`define FSH_C_TACHO   16'h0040
`define FSH_C_ENC     16'h0080
`define FSH_C_FIELD   16'h0100
`define FSH_C_RXERR   16'h0800
`define FSH_C_STALL   16'h1000
`define FSH_C_REMOTE  16'hF006
// system and configuration codes start here, never raised by this block
`define FSH_C_SYS_LO  16'hF200
`endif

// ==== logic/fsh_pkg.sv ====
// types shared by the fault supervisor files
package fsh_pkg;
	// software control word
	typedef struct packed {
		logic serialSlave;
		logic external_halt_enable;
		logic encoderEnable;
		logic tacho_mismatch_enable;
		logic tripReset;
		logic stallEnable;
		logic rxErrEnable;
		logic fieldFailEnable;
	} fsh_ctrl_t;
	// monitored pins, all asynchronous to the clock
	typedef struct packed {
		logic fieldFail;
		logic thermistor;
		logic encoderFault;
		logic remoteTrip;
		logic start_run_input;
		logic speed_is_zero;
		logic setpoint_is_zero;
	} fsh_pins_t;
	// sequencer states
	typedef enum logic [1:0] {
		FSH_SEQ_STOP = 2'b00,
		FSH_SEQ_RUN  = 2'b01,
		FSH_SEQUENCER_HOLD_STATE = 2'b10
	} fsh_seq_t;
endpackage : fsh_pkg

// ==== logic/fsh_delay_timer.sv ====
// delay timer counting whole 0.1 s ticks while its condition holds
`timescale 1ns/1ns
`include "fsh_defs.svh"
module fsh_delay_timer #(
	parameter int TICK_CYCLES = `FSH_TICK_CYC
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// condition and limit in ticks
	input  wire logic        run,
	input  wire logic [15:0] limit,
	// condition held for the full limit
	output logic             expired
);
	logic [`FSH_TCNT_W-1:0] sub_reg;   // cycles within a tick
	logic [15:0]            tick_reg;  // whole ticks seen
	logic                   tickEnd;   // last cycle of a tick

	assign tickEnd = (sub_reg == `FSH_TCNT_W'(TICK_CYCLES - 1));

	// prescaler restarts with the condition, so the delay is exact
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sub_reg <= '0;
		end else if (!run || tickEnd) begin
			sub_reg <= '0;
		end else begin
			sub_reg <= sub_reg + 1'b1;
		end
	end

	// tick counter saturates
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= '0;
		end else if (!run) begin
			tick_reg <= '0;
		end else if (tickEnd && tick_reg != 16'hFFFF) begin
			tick_reg <= tick_reg + 1'b1;
		end
	end

	// expiry is registered and drops on the clock edge after the condition goes away
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			expired <= 1'b0;
		end else begin
			expired <= run && (tick_reg >= limit);
		end
	end
endmodule : fsh_delay_timer

// ==== logic/fsh_fault_supervisor.sv ====
// fault supervisor: alarm gating, latching, health words and alarm history
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "fsh_defs.svh"
module fsh_fault_supervisor #(
	parameter int TICK_CYCLES = `FSH_TICK_CYC
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// monitored pins
	input  wire fsh_pkg::fsh_pins_t pinsAsync,
	// measurements from the control loop, same clock
	input  wire logic [15:0]        armatureCurrent,
	input  wire logic signed [15:0] speedFeedback,
	input  wire logic signed [15:0] armatureVolts,
	input  wire logic               serialMsgStrobe,
	// drive side outputs
	output logic                    drive_ok_output,
	output logic                    panel_ok_lamp,
	output logic                    sequencer_hold_state,
	output logic                    contactorOpen
);
	// control registers
	fsh_pkg::fsh_ctrl_t ctrl_reg;     // enables and modes
	logic [15:0]        stallThr_reg; // 0.01 % units
	logic [15:0]        tachoLvl_reg; // 0.1 % units
	logic [15:0]        stallDly_reg; // 0.1 s units
	logic [15:0]        haltDly_reg;  // 0.1 s units
	// synchronised pins
	logic [6:0]         pinMeta_reg;
	logic [6:0]         pinSync_reg;
	fsh_pkg::fsh_pins_t pins;
	// edges
	logic               runDly_reg;
	logic               trDly_reg;
	logic               runRise;
	logic               trRise;
	logic               clearFaults;
	// detectors
	logic               stallCond;
	logic signed [16:0] speedDiff;
	logic [16:0]        absDiff;
	logic               mismatchNow;
	logic               tacho_mismatch_flag;
	logic [2:0]         tmrRun;
	logic [15:0]        tmrLimit [3];
	logic [2:0]         tmrDone;
	logic               serial_setpoint_rx_fault;
	// alarm bookkeeping
	logic [15:0]        alarmBits;
	logic [15:0]        newBits;
	logic [15:0]        recBit;
	logic               recRemote;
	logic               record;
	logic [15:0]        recCode;
	logic [15:0]        stored_reg;
	logic [15:0]        storedNext;
	logic               remStored_reg;
	logic               remNext;
	logic               anyFault;
	logic               anyNext;
	logic [15:0]        health_reg;
	logic [15:0]        first_reg;
	logic [15:0]        last_reg;
	logic [15:0]        hist_reg [`FSH_DEPTH];
	// sequencer
	fsh_pkg::fsh_seq_t  seq_reg;
	fsh_pkg::fsh_seq_t  seqNext;
	// bus decode
	logic               setup;
	logic               hit;
	logic               wrEn;
	logic [7:0]         histOff;
	logic [`FSH_HIDX_W-1:0] histIdx;
	logic [31:0]        rdMux;
	logic [15:0]        statusWord;

	// clamp a delay to its legal range
	function automatic logic [15:0] clampDly(input logic [15:0] v);
		if (v < `FSH_DLY_MIN) begin
			clampDly = `FSH_DLY_MIN;
		end else if (v > `FSH_DLY_MAX) begin
			clampDly = `FSH_DLY_MAX;
		end else begin
			clampDly = v;
		end
	endfunction : clampDly

	// two-stage pin synchroniser
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= pinsAsync;
			pinSync_reg <= pinMeta_reg;
		end
	end
	assign pins = fsh_pkg::fsh_pins_t'(pinSync_reg);

	// edge detectors for run command and auto reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			runDly_reg <= 1'b0;
			trDly_reg  <= 1'b1;
		end else begin
			runDly_reg <= pins.start_run_input;
			trDly_reg  <= ctrl_reg.tripReset;
		end
	end
	assign runRise = pins.start_run_input && !runDly_reg;
	assign trRise  = ctrl_reg.tripReset && !trDly_reg;
	// clear on auto reset enable, or on run while enabled
	assign clearFaults = trRise || (ctrl_reg.tripReset && runRise);

	// stall comparator
	assign stallCond = (armatureCurrent > stallThr_reg)
		&& pins.speed_is_zero && !pins.setpoint_is_zero;

	// tacho versus armature voltage mismatch
	assign speedDiff   = 17'(speedFeedback) - 17'(armatureVolts);
	assign absDiff     = speedDiff[16] ? 17'(-speedDiff) : 17'(speedDiff);
	assign mismatchNow = absDiff > {1'b0, tachoLvl_reg};

	// mismatch flag runs regardless of the enable
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tacho_mismatch_flag <= 1'b0;
		end else begin
			tacho_mismatch_flag <= mismatchNow;
		end
	end

	// timer 0 stall, 1 remote trip, 2 serial receive watchdog
	assign tmrRun[0]   = stallCond;
	assign tmrRun[1]   = pins.remoteTrip && ctrl_reg.external_halt_enable;
	assign tmrRun[2]   = ctrl_reg.serialSlave && !serialMsgStrobe;
	assign tmrLimit[0] = stallDly_reg;
	assign tmrLimit[1] = haltDly_reg;
	assign tmrLimit[2] = `FSH_RX_TOUT;
	assign serial_setpoint_rx_fault = tmrDone[2];

	// one delay timer per timed alarm
	genvar gt;
	for (gt = 0; gt < 3; gt++) begin : g_tmr
		fsh_delay_timer #(
			.TICK_CYCLES (TICK_CYCLES)
		) u_tmr (
			.clock   (clock),
			.rst_n   (rst_n),
			.run     (tmrRun[gt]),
			.limit   (tmrLimit[gt]),
			.expired (tmrDone[gt])
		);
	end

	// present alarms, each gated by its own enable except the thermistor, which is never gated
	always_comb begin
		alarmBits = `FSH_C_NONE;
		if (pins.thermistor) begin
			alarmBits = alarmBits | `FSH_C_THERM;
		end
		if (ctrl_reg.tacho_mismatch_enable && tacho_mismatch_flag) begin
			alarmBits = alarmBits | `FSH_C_TACHO;
		end
		if (ctrl_reg.encoderEnable && pins.encoderFault) begin
			alarmBits = alarmBits | `FSH_C_ENC;
		end
		if (ctrl_reg.fieldFailEnable && pins.fieldFail) begin
			alarmBits = alarmBits | `FSH_C_FIELD;
		end
		if (ctrl_reg.rxErrEnable && ctrl_reg.serialSlave && serial_setpoint_rx_fault) begin
			alarmBits = alarmBits | `FSH_C_RXERR;
		end
		if (ctrl_reg.stallEnable && tmrDone[0]) begin
			alarmBits = alarmBits | `FSH_C_STALL;
		end
	end

	// one new alarm is recorded per cycle, lowest bit first
	assign newBits   = alarmBits & ~stored_reg;
	assign recBit    = newBits & (~newBits + 16'h0001);
	assign recRemote = tmrDone[1] && !remStored_reg && (newBits == `FSH_C_NONE);
	assign record    = (newBits != `FSH_C_NONE) || recRemote;
	assign recCode   = recRemote ? `FSH_C_REMOTE : recBit;

	// a new alarm wins over a clear in the same cycle
	assign storedNext = (clearFaults ? `FSH_C_NONE : stored_reg) | recBit;
	assign remNext    = (!clearFaults && remStored_reg) || recRemote;
	assign anyFault   = (stored_reg != `FSH_C_NONE) || remStored_reg;
	assign anyNext    = (storedNext != `FSH_C_NONE) || remNext;

	// fault latch, only cleared by the auto reset paths
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stored_reg    <= `FSH_C_NONE;
			remStored_reg <= 1'b0;
		end else begin
			stored_reg    <= storedNext;
			remStored_reg <= remNext;
		end
	end

	// health word shows the alarms present now
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			health_reg <= `FSH_C_NONE;
		end else begin
			health_reg <= alarmBits;
		end
	end

	// first fault store, refilled after a clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			first_reg <= `FSH_C_NONE;
		end else if (record && (!anyFault || clearFaults)) begin
			first_reg <= recCode;
		end else if (clearFaults) begin
			first_reg <= `FSH_C_NONE;
		end
	end

	// most recent alarm
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_reg <= `FSH_C_NONE;
		end else if (record) begin
			last_reg <= recCode;
		end else if (clearFaults) begin
			last_reg <= `FSH_C_NONE;
		end
	end

	// history shift register, slot 0 newest
	genvar gh;
	for (gh = 0; gh < `FSH_DEPTH; gh++) begin : g_hist
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				hist_reg[gh] <= `FSH_C_NONE;
			end else if (record) begin
				if (gh == 0) begin
					hist_reg[gh] <= recCode;
				end else begin
					hist_reg[gh] <= hist_reg[(gh == 0) ? 0 : gh - 1];
				end
			end
		end
	end

	// sequencer next state
	always_comb begin
		case (seq_reg)
			fsh_pkg::FSH_SEQ_STOP: begin
				if (anyNext) begin
					seqNext = fsh_pkg::FSH_SEQUENCER_HOLD_STATE;
				end else if (pins.start_run_input) begin
					seqNext = fsh_pkg::FSH_SEQ_RUN;
				end else begin
					seqNext = fsh_pkg::FSH_SEQ_STOP;
				end
			end
			fsh_pkg::FSH_SEQ_RUN: begin
				if (anyNext) begin
					seqNext = fsh_pkg::FSH_SEQUENCER_HOLD_STATE;
				end else if (!pins.start_run_input) begin
					seqNext = fsh_pkg::FSH_SEQ_STOP;
				end else begin
					seqNext = fsh_pkg::FSH_SEQ_RUN;
				end
			end
			fsh_pkg::FSH_SEQUENCER_HOLD_STATE: begin
				// stays while anything is stored
				if (anyNext) begin
					seqNext = fsh_pkg::FSH_SEQUENCER_HOLD_STATE;
				end else begin
					seqNext = fsh_pkg::FSH_SEQ_STOP;
				end
			end
			default: begin
				seqNext = fsh_pkg::FSH_SEQ_STOP;
			end
		endcase
	end

	// sequencer state and drive outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg              <= fsh_pkg::FSH_SEQ_STOP;
			sequencer_hold_state <= 1'b0;
			drive_ok_output      <= 1'b1;
			panel_ok_lamp        <= 1'b1;
			contactorOpen        <= 1'b0;
		end else begin
			seq_reg              <= seqNext;
			sequencer_hold_state <= (seqNext == fsh_pkg::FSH_SEQUENCER_HOLD_STATE);
			drive_ok_output      <= !anyNext;
			panel_ok_lamp        <= !anyNext;
			contactorOpen        <= anyNext;
		end
	end

	// status word
	assign statusWord = {8'h00, sequencer_hold_state, contactorOpen, drive_ok_output,
		serial_setpoint_rx_fault, pins.remoteTrip, tmrDone[0],
		tacho_mismatch_flag, pins.thermistor};

	// bus decode
	assign setup   = psel && !penable;
	assign hit     = (paddr[1:0] == 2'b00) && (paddr <= `FSH_A_HEND);
	assign wrEn    = psel && penable && pready && pwrite && hit;
	assign histOff = paddr - `FSH_A_HIST;
	assign histIdx = histOff[`FSH_HIDX_W+1:2];

	// read multiplexer
	always_comb begin
		rdMux = 32'h0000_0000;
		case (paddr)
			`FSH_A_CTRL:   rdMux = {24'h000000, ctrl_reg};
			`FSH_A_STTHR:  rdMux = {16'h0000, stallThr_reg};
			`FSH_A_TACHO:  rdMux = {16'h0000, tachoLvl_reg};
			`FSH_A_STDLY:  rdMux = {16'h0000, stallDly_reg};
			`FSH_A_RTDLY:  rdMux = {16'h0000, haltDly_reg};
			`FSH_A_STAT:   rdMux = {16'h0000, statusWord};
			`FSH_A_HEALTH: rdMux = {16'h0000, health_reg};
			`FSH_A_FIRST:  rdMux = {16'h0000, first_reg};
			`FSH_A_LAST:   rdMux = {16'h0000, last_reg};
			default: begin
				// history window
				if (hit && paddr >= `FSH_A_HIST) begin
					rdMux = {16'h0000, hist_reg[histIdx]};
				end
			end
		endcase
	end

	// apb answer: one wait-free access phase, data latched in setup
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit;
			if (setup) begin
				prdata <= (pwrite || !hit) ? 32'h0000_0000 : rdMux;
			end
		end
	end

	// software writes, clamped to legal ranges
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= fsh_pkg::fsh_ctrl_t'(`FSH_CTRL_RST);
			stallThr_reg <= `FSH_STTHR_RST;
			tachoLvl_reg <= `FSH_TACHO_RST;
			stallDly_reg <= `FSH_STDLY_RST;
			haltDly_reg  <= `FSH_RTDLY_RST;
		end else if (wrEn) begin
			case (paddr)
				`FSH_A_CTRL:  ctrl_reg <= fsh_pkg::fsh_ctrl_t'(pwdata[7:0]);
				`FSH_A_STTHR: stallThr_reg <= (pwdata[15:0] > `FSH_STTHR_MAX) ?
					`FSH_STTHR_MAX : pwdata[15:0];
				`FSH_A_TACHO: tachoLvl_reg <= (pwdata[15:0] > `FSH_TACHO_MAX) ?
					`FSH_TACHO_MAX : pwdata[15:0];
				`FSH_A_STDLY: stallDly_reg <= clampDly(pwdata[15:0]);
				`FSH_A_RTDLY: haltDly_reg <= clampDly(pwdata[15:0]);
				default: begin
					// read-only or history: ignored
				end
			endcase
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_hist_shift;
		record |=> hist_reg[`FSH_DEPTH-1] == $past(hist_reg[`FSH_DEPTH-2]);
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("history did not shift");

	property p_newest_last;
		(anyFault && last_reg != `FSH_C_NONE) |-> hist_reg[0] == last_reg;
	endproperty
	a_newest_last: assert property (p_newest_last) else $error("newest differs from last");

	property p_latched;
		(anyFault && !ctrl_reg.tripReset)
			|=> !drive_ok_output && !panel_ok_lamp && contactorOpen;
	endproperty
	a_latched: assert property (p_latched) else $error("fault latch released");

	property p_hold;
		(seq_reg == fsh_pkg::FSH_SEQUENCER_HOLD_STATE && anyFault && !clearFaults)
			|=> seq_reg == fsh_pkg::FSH_SEQUENCER_HOLD_STATE;
	endproperty
	a_hold: assert property (p_hold) else $error("hold left with fault stored");

	property p_clear_on_enable;
		(trRise && !record) |=> (stored_reg == `FSH_C_NONE) && !remStored_reg;
	endproperty
	a_clear_on_enable: assert property (p_clear_on_enable) else $error("enable clear missed");

	property p_clear_on_run;
		(ctrl_reg.tripReset && runRise && !record) |=> !anyFault ##1 drive_ok_output;
	endproperty
	a_clear_on_run: assert property (p_clear_on_run) else $error("run clear missed");

	property p_stall_inhibit;
		!ctrl_reg.stallEnable |-> (alarmBits & `FSH_C_STALL) == `FSH_C_NONE;
	endproperty
	a_stall_inhibit: assert property (p_stall_inhibit) else $error("inhibited stall raised");

	property p_rx_slave;
		!ctrl_reg.serialSlave |-> (alarmBits & `FSH_C_RXERR) == `FSH_C_NONE;
	endproperty
	a_rx_slave: assert property (p_rx_slave) else $error("receive error outside slave");

	property p_stall_cause;
		$rose(tmrDone[0]) |-> $past(stallCond) && $past(stallCond, 2);
	endproperty
	a_stall_cause: assert property (p_stall_cause) else $error("stall without condition");

	property p_first;
		(record && !anyFault) |=> first_reg == $past(recCode);
	endproperty
	a_first: assert property (p_first) else $error("first fault not captured");

	// recorded codes are single bits or the remote trip, below the system range
	property p_code_family;
		record |-> ($onehot(recCode) || recCode == `FSH_C_REMOTE)
			&& (recCode < `FSH_C_SYS_LO);
	endproperty
	a_code_family: assert property (p_code_family) else $error("bad alarm code");

	property p_tacho_flag;
		(!ctrl_reg.tacho_mismatch_enable && mismatchNow) |=> tacho_mismatch_flag;
	endproperty
	a_tacho_flag: assert property (p_tacho_flag) else $error("tacho flag frozen");

	property p_therm;
		pins.thermistor |=> (health_reg & `FSH_C_THERM) != `FSH_C_NONE;
	endproperty
	a_therm: assert property (p_therm) else $error("thermistor bit missing");

	c_stall: cover property (record && recCode == `FSH_C_STALL);
	c_remote: cover property (record && recCode == `FSH_C_REMOTE);
	c_run_clear: cover property (anyFault && clearFaults && runRise);
	c_hist_full: cover property (hist_reg[`FSH_DEPTH-1] != `FSH_C_NONE);
endmodule : fsh_fault_supervisor

// ==== bench/fsh_drive_model.sv ====
// far side model: pin levels and serial setpoint messages
`timescale 1ns/1ns
module fsh_drive_model (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// requested pin levels and message stream on/off
	input  wire fsh_pkg::fsh_pins_t want,
	input  wire logic               msgOn,
	// levels seen by the block
	output fsh_pkg::fsh_pins_t      pinsAsync,
	output logic                    serialMsgStrobe
);
	logic [2:0] gapCnt; // spacing of messages
	// pins follow the request one edge later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) pinsAsync <= '0;
		else pinsAsync <= want;
	end
	// one message every five cycles, silent when off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gapCnt <= 3'h0;
			serialMsgStrobe <= 1'b0;
		end else begin
			gapCnt <= (gapCnt == 3'h4) ? 3'h0 : gapCnt + 3'h1;
			serialMsgStrobe <= msgOn && gapCnt == 3'h4;
		end
	end
endmodule : fsh_drive_model

// ==== bench/testbench.sv ====
// self-checking bench of the fault supervisor
`timescale 1ns/1ns
`include "fsh_defs.svh"
module testbench;
	logic               clock, rst_n, psel, penable, pwrite, pready, pslverr, msgOn, strobe;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata;
	logic [15:0]        cur;
	logic signed [15:0] spd, vlt;
	logic               ok, lamp, hold, opn;
	fsh_pkg::fsh_pins_t want, pins;
	int                 n_mismatch, compares;
	logic [15:0]        hq[$]; // expected history, newest first
	fsh_fault_supervisor #(.TICK_CYCLES(10)) i_fsh_fault_supervisor (.clock(clock), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pinsAsync(pins),
		.armatureCurrent(cur), .speedFeedback(spd), .armatureVolts(vlt),
		.serialMsgStrobe(strobe), .drive_ok_output(ok), .panel_ok_lamp(lamp),
		.sequencer_hold_state(hold), .contactorOpen(opn));
	fsh_drive_model i_fsh_drive_model (.clock(clock), .rst_n(rst_n), .want(want), .msgOn(msgOn),
		.pinsAsync(pins), .serialMsgStrobe(strobe));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// apb transfer, entered just after a rising edge; answer taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {16'h0000, d}, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q & m, x);
	endtask : rd
	// sample the drive side outputs mid-cycle
	task automatic outs(input logic xok, input logic xopn);
		@(negedge clock);
		chk({lamp, ok, opn}, {xok, xok, xopn});
		@(posedge clock);
	endtask : outs
	task automatic rec(input logic [15:0] c);
		hq.push_front(c);
		if (hq.size() > 10) void'(hq.pop_back());
		rd(`FSH_A_LAST, 32'hFFFF, c);
	endtask : rec
	task automatic run_pulse;
		cyc(1);
		want.start_run_input <= 1'b1;
		cyc(5);
		want.start_run_input <= 1'b0;
		cyc(5);
	endtask : run_pulse
	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		rd(`FSH_A_CTRL, 32'hFFFFFFFF, 32'h7F);
		for (int a = 32'h18; a <= 32'h48; a += 4) rd(8'(a), 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h4C, 32'h0, q, e);
		chk(e, 1'b1);
		chk(q, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_latch;
		wr(`FSH_A_CTRL, 16'h0077);
		want.fieldFail <= 1'b1;
		cyc(6);
		rec(16'h0100);
		want.thermistor <= 1'b1;
		cyc(6);
		rec(16'h0010);
		rd(`FSH_A_FIRST, 32'hFFFF, 32'h0100);
		rd(`FSH_A_HEALTH, 32'hFFFF, 32'h0110);
		rd(`FSH_A_STAT, 32'h1, 32'h1);
		want <= '0;
		run_pulse();
		outs(1'b0, 1'b1);
		chk(hold, 1'b1);
		wr(`FSH_A_CTRL, 16'h007F);
		cyc(2);
		outs(1'b1, 1'b0);
		rd(`FSH_A_FIRST, 32'hFFFF, 32'h0);
		$display("test latch done");
	endtask : t_latch
	task automatic t_inhibit;
		wr(`FSH_A_CTRL, 16'h004E);
		want.fieldFail <= 1'b1;
		want.encoderFault <= 1'b1;
		spd <= 16'sd500;
		cyc(8);
		outs(1'b1, 1'b0);
		rd(`FSH_A_STAT, 32'h2, 32'h0);
		vlt <= -16'sd1;
		cyc(3);
		rd(`FSH_A_STAT, 32'h2, 32'h2);
		want <= '0;
		spd <= 16'sd0;
		vlt <= 16'sd0;
		cyc(1);
		want.thermistor <= 1'b1;
		cyc(6);
		rec(16'h0010);
		want.thermistor <= 1'b0;
		run_pulse();
		outs(1'b1, 1'b0);
		$display("test inhibit done");
	endtask : t_inhibit
	task automatic t_stall(input logic [15:0] c, input logic en);
		wr(`FSH_A_STDLY, 16'h0002);
		wr(`FSH_A_CTRL, en ? 16'h007F : 16'h007B);
		want.speed_is_zero <= 1'b1;
		cur <= 16'h2710;
		cyc(10);
		rd(`FSH_A_STAT, 32'h4, 32'h0);
		cyc(25);
		rd(`FSH_A_STAT, 32'h4, 32'h4);
		outs(!en, en);
		if (en) rec(c);
		cur <= 16'h0;
		run_pulse();
		$display("test stall done");
	endtask : t_stall
	task automatic t_remote;
		wr(`FSH_A_RTDLY, 16'h0003);
		want.remoteTrip <= 1'b1;
		cyc(15);
		outs(1'b1, 1'b0);
		cyc(30);
		outs(1'b0, 1'b1);
		rec(16'hF006);
		want <= '0;
		run_pulse();
		$display("test remote done");
	endtask : t_remote
	task automatic t_serial;
		msgOn <= 1'b1;
		wr(`FSH_A_CTRL, 16'h00FF);
		cyc(40);
		outs(1'b1, 1'b0);
		msgOn <= 1'b0;
		cyc(30);
		rec(16'h0800);
		wr(`FSH_A_CTRL, 16'h007F);
		run_pulse();
		outs(1'b1, 1'b0);
		$display("test serial done");
	endtask : t_serial
	task automatic t_history;
		for (int k = 0; k < 6; k++) begin
			if (k[0]) want.fieldFail <= 1'b1;
			else want.thermistor <= 1'b1;
			cyc(6);
			rec(k[0] ? 16'h0100 : 16'h0010);
			want <= '0;
			run_pulse();
		end
		for (int i = 0; i < 10; i++) rd(8'(`FSH_A_HIST + 4 * i), 32'hFFFF, hq[i]);
		$display("test history done");
	endtask : t_history
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{rst_n, psel, penable, pwrite, msgOn, paddr, pwdata, cur, spd, vlt, want} = '0;
		n_mismatch = 0;
		compares = 0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_latch();
		t_inhibit();
		t_stall(16'h1000, 1'b0);
		t_stall(16'h1000, 1'b1);
		t_remote();
		t_serial();
		t_history();
		tally_and_finish();
	end
endmodule : testbench
